// file: inc/lsq_pkg.sv
package lsq_pkg;
	localparam int unsigned CLK_HZ    = 25_000_000;
	localparam int unsigned CLK_NS    = 1_000_000_000 / CLK_HZ;
	localparam int unsigned TOUT_NS   = 10_000;
	localparam int unsigned TOUT_CYC  = (TOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TOUT_W    = $clog2(TOUT_CYC + 1);
	localparam int unsigned MAX_STEPS = 100;
	localparam int unsigned IDX_W     = 7;
	localparam int unsigned VAL_W     = 16;
	localparam int unsigned TIME_W    = 16;
	localparam int unsigned DLY_W     = 12;
	localparam int unsigned DLY_MAX   = 3600;
	localparam int unsigned CNT_W     = 9;
	localparam int unsigned CNT_MIN   = 1;
	localparam int unsigned CNT_MAX   = 256;
	localparam int unsigned NPINS     = 4;
	localparam int unsigned AW        = 8;

	localparam logic [AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [AW-1:0] OFF_CFG  = 8'h04;
	localparam logic [AW-1:0] OFF_SEL  = 8'h08;
	localparam logic [AW-1:0] OFF_STV  = 8'h0C;
	localparam logic [AW-1:0] OFF_STI  = 8'h10;
	localparam logic [AW-1:0] OFF_STT  = 8'h14;
	localparam logic [AW-1:0] OFF_DCV  = 8'h18;
	localparam logic [AW-1:0] OFF_DCI  = 8'h1C;
	localparam logic [AW-1:0] OFF_TRV  = 8'h20;
	localparam logic [AW-1:0] OFF_TRI  = 8'h24;
	localparam logic [AW-1:0] OFF_DLY  = 8'h28;
	localparam logic [AW-1:0] OFF_CNT  = 8'h2C;
	localparam logic [AW-1:0] OFF_STAT = 8'h30;
	localparam logic [AW-1:0] OFF_DIO  = 8'h34;

	localparam int C_INIT  = 0;
	localparam int C_ABORT = 1;
	localparam int C_ADD   = 2;
	localparam int C_DEL   = 3;
	localparam int C_CLR   = 4;
	localparam int C_RMT   = 5;
	localparam int C_KEY   = 6;
	localparam int T_BOS   = 16;
	localparam int T_EOS   = 17;
	localparam int S_IDX   = 8;
	localparam int S_LEN   = 16;
	localparam int S_PASS  = 23;
	localparam int D_POL   = 8;

	typedef logic [IDX_W-1:0] idx_t;
	typedef enum logic [1:0] {MODE_FIX = 2'h0, MODE_STEP = 2'h1, MODE_LIST = 2'h2} mode_t;
	typedef enum logic [1:0] {SRC_KEY = 2'h0, SRC_IO = 2'h1, SRC_RMT = 2'h2} src_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_ARMED = 3'h1, ST_DELAY = 3'h2, ST_RUN = 3'h3, ST_ADELAY = 3'h4
	} state_t;
	typedef struct packed {
		logic  tout_pos;
		logic  cont;
		src_t  src;
		mode_t imode;
		mode_t vmode;
		logic  pace_trg;
		logic  after_list;
	} cfg_t;
	localparam int unsigned CFG_W = $bits(cfg_t);
	localparam cfg_t CFG_RST = '{1'b1, 1'b0, SRC_KEY, MODE_FIX, MODE_FIX, 1'b0, 1'b0};
	localparam logic [DLY_W-1:0] DLY_RST = 12'h000;
	localparam logic [CNT_W-1:0] CNT_RST = 9'h001;
	typedef struct packed {
		logic              eos;
		logic              bos;
		logic [TIME_W-1:0] t;
		logic [VAL_W-1:0]  i;
		logic [VAL_W-1:0]  v;
	} entry_t;
	typedef struct packed {
		logic [VAL_W-1:0] i;
		logic [VAL_W-1:0] v;
	} setpt_t;
	typedef struct packed {
		logic          psel;
		logic          penable;
		logic          pwrite;
		logic [AW-1:0] paddr;
		logic [31:0]   pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;
endpackage

// file: tb/lsq_far_end.sv
module lsq_far_end (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       fire,
	input  wire logic       trig_out,
	output logic [3:0]      dio_in,
	output int              pulses,
	output int              width
);
	timeunit 1ns;
	timeprecision 1ns;
	int hold;
	int run;
	// Pins idle high; a fire request pulls pin 1 low far longer than the minimum width.
	assign dio_in = (hold > 0) ? 4'b1101 : 4'b1111;
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			hold <= 0;
			run <= 0;
			pulses <= 0;
			width <= 0;
		end else begin
			if (fire)
				hold <= 60;
			else if (hold > 0)
				hold <= hold - 1;
			if (trig_out === 1'b1)
				run <= run + 1;
			else if (run > 0) begin
				width <= run;
				pulses <= pulses + 1;
				run <= 0;
			end
		end
	end
endmodule

// file: tb/output_list_sequencer_tb_top.sv
module output_list_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk_sys = 1'b0;
	logic              sys_rst = 1'b1;
	logic              fire = 1'b0;
	lsq_pkg::apb_req_t req = '0;
	lsq_pkg::apb_rsp_t rsp;
	lsq_pkg::setpt_t   set_out;
	logic [3:0]        dio_in;
	logic              trig_out;
	logic              busy;
	logic [31:0]       rdv;
	logic              err;
	int                pulses;
	int                width;
	int                fails = 0;
	int                cmp_count = 0;
	int                cyc = 0;
	always #20 clk_sys = ~clk_sys;
	output_list_sequencer #(.SEC_CYC(20)) dut (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.ce      (1'b1),
		.apb_req (req),
		.apb_rsp (rsp),
		.dio_in  (dio_in),
		.set_out (set_out),
		.trig_out(trig_out),
		.busy    (busy)
	);
	lsq_far_end far_end (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.fire    (fire),
		.trig_out(trig_out),
		.dio_in  (dio_in),
		.pulses  (pulses),
		.width   (width)
	);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (rsp.pready !== 1'b1);
		rdv = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk("pslverr", {31'h0, err}, {31'h0, e});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
			input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rdv & m, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic idle();
		int n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		chk("busy low", {31'h0, busy}, 32'h0);
		// Setpoints settle one edge after busy falls.
		@(posedge clk_sys);
	endtask
	task automatic pin();
		fire <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
	endtask
	task automatic t_regs();
		rd(lsq_pkg::OFF_CFG, '1, 32'h0000_0200, "cfg");
		rd(lsq_pkg::OFF_DLY, '1, 32'h0, "dly");
		rd(lsq_pkg::OFF_CNT, '1, 32'h1, "cnt");
		wr(8'hFC, 32'h0, 1'b1);
		chk("trig idle", {31'h0, trig_out}, 32'h0);
	endtask
	task automatic t_limits();
		logic [7:0] a[7] = '{8'h04, 8'h04, 8'h28, 8'h28, 8'h2C, 8'h2C, 8'h2C};
		logic [31:0] d[7] = '{32'h224, 32'h218, 32'hE10, 32'hE11, 32'h0, 32'h100, 32'h101};
		logic e[7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		for (int k = 0; k < 7; k++) begin
			wr(a[k], d[k], e[k]);
		end
		rd(lsq_pkg::OFF_CNT, '1, 32'h100, "cnt max");
		wr(lsq_pkg::OFF_CNT, 32'h1, 1'b0);
	endtask
	task automatic t_edit();
		wr(lsq_pkg::OFF_CTRL, 32'h4, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h10, 1'b0);
		rd(lsq_pkg::OFF_STAT, 32'h007F_0000, 32'h0, "len clr");
		wr(lsq_pkg::OFF_CTRL, 32'h4, 1'b0);
		wr(lsq_pkg::OFF_STV, 32'h1111, 1'b0);
		wr(lsq_pkg::OFF_STI, 32'h2222, 1'b0);
		wr(lsq_pkg::OFF_STT, 32'h1_0001, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h4, 1'b0);
		rd(lsq_pkg::OFF_STV, '1, 32'h1111, "copy v");
		rd(lsq_pkg::OFF_STT, '1, 32'h1_0001, "copy t");
		wr(lsq_pkg::OFF_STV, 32'h3333, 1'b0);
		wr(lsq_pkg::OFF_STT, 32'h2_000E, 1'b0);
		wr(lsq_pkg::OFF_SEL, 32'h0, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h4, 1'b0);
		rd(lsq_pkg::OFF_STAT, 32'h007F_7F00, 32'h0003_0000, "len idx");
		rd(lsq_pkg::OFF_SEL, '1, 32'h1, "sel new");
		wr(lsq_pkg::OFF_SEL, 32'h2, 1'b0);
		rd(lsq_pkg::OFF_STV, '1, 32'h3333, "shifted");
		wr(lsq_pkg::OFF_SEL, 32'h1, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h8, 1'b0);
		rd(lsq_pkg::OFF_STAT, 32'h007F_0000, 32'h0002_0000, "len del");
	endtask
	task automatic t_dwell();
		wr(lsq_pkg::OFF_DCV, 32'hAAA, 1'b0);
		wr(lsq_pkg::OFF_DCI, 32'hBBB, 1'b0);
		wr(lsq_pkg::OFF_CFG, 32'h228, 1'b0);
		wr(lsq_pkg::OFF_DLY, 32'h1, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h1, 1'b0);
		wr(lsq_pkg::OFF_DLY, 32'h0, 1'b1);
		wr(lsq_pkg::OFF_CTRL, 32'h4, 1'b1);
		wr(lsq_pkg::OFF_CTRL, 32'h40, 1'b0);
		tick(8);
		chk("delay dc", set_out, 32'h0BBB_0AAA);
		tick(20);
		chk("step0", set_out, 32'h2222_1111);
		tick(20);
		chk("step1", set_out, 32'h2222_3333);
		idle();
		chk("revert", set_out, 32'h0BBB_0AAA);
		tick(300);
		chk("pulses", pulses, 32'h2);
		chk("width", width, 32'h0000_00FA);
	endtask
	task automatic t_repeat();
		wr(lsq_pkg::OFF_CFG, 32'h2A9, 1'b0);
		wr(lsq_pkg::OFF_DLY, 32'h0, 1'b0);
		wr(lsq_pkg::OFF_CNT, 32'h2, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h1, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h20, 1'b0);
		tick(330);
		chk("pass2", {31'h0, busy}, 32'h1);
		idle();
		chk("hold last", set_out, 32'h2222_3333);
		rd(lsq_pkg::OFF_STAT, 32'hFF80_0000, 32'h0100_0000, "passes");
		wr(lsq_pkg::OFF_CFG, 32'h3A9, 1'b0);
		wr(lsq_pkg::OFF_CNT, 32'h1, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h1, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h20, 1'b0);
		tick(700);
		chk("cont", {31'h0, busy}, 32'h1);
		wr(lsq_pkg::OFF_CTRL, 32'h2, 1'b0);
		idle();
	endtask
	task automatic t_tpace();
		wr(lsq_pkg::OFF_CFG, 32'h26A, 1'b0);
		wr(lsq_pkg::OFF_DIO, 32'h2, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h1, 1'b0);
		pin();
		tick(70);
		chk("wait trig", set_out, 32'h2222_1111);
		pin();
		tick(10);
		chk("trig adv", set_out, 32'h2222_3333);
		wr(lsq_pkg::OFF_CTRL, 32'h2, 1'b0);
		idle();
		chk("abort dc", set_out, 32'h0BBB_0AAA);
	endtask
	task automatic t_step();
		wr(lsq_pkg::OFF_TRV, 32'hCCC, 1'b0);
		wr(lsq_pkg::OFF_CFG, 32'h204, 1'b0);
		wr(lsq_pkg::OFF_CTRL, 32'h1, 1'b0);
		chk("step before", set_out, 32'h0BBB_0AAA);
		wr(lsq_pkg::OFF_CTRL, 32'h40, 1'b0);
		idle();
		chk("step level", set_out, 32'h0BBB_0CCC);
	endtask
	task automatic final_report();
		$display("fails=%0d comparisons=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// The ceiling sits well above the few thousand cycles the scenarios need.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_regs();
		t_limits();
		t_edit();
		t_dwell();
		t_repeat();
		t_tpace();
		t_step();
		final_report();
	end
endmodule

// file: verilog/output_list_sequencer.sv
// Summary of operation
// - List holds up to 100 voltage/current steps
// - Add inserts after selected, shifting later down
// - New entry copies preceding entry fields
// - Delete removes selected; clear empties list
// - Each entry has run time in seconds
// - Begin flag pulses trigger out at step start
// - End flag pulses trigger out at step end
// - After-list DC reverts to prior setpoint
// - After-list list holds final step setpoints
// - Dwell pacing advances when run time expires
// - Trigger pacing advances on selected trigger
// - Trigger pacing holds step until trigger arrives
// - Fixed mode keeps immediate setpoint always
// - Step mode trigger moves to triggered level
// - List mode trigger follows list entries
// - Reject step/list mode combination
// - Run key source is default
// - Digital pin source uses trigger-input pins
// - Remote command source accepted
// - Trigger delay 0 to 3600 s, default 0
// - Repeat count 1 to 256, default 1
// - Continuous repeats forever, ignores count
// - Trigger out pulse 10 us, configured polarity
// - Input edge by pin polarity
// - List properties locked while initiated
//
// The address map and register access over APB were chosen for this implementation.
module output_list_sequencer #(
	parameter int unsigned SEC_CYC   = lsq_pkg::CLK_HZ,
	parameter int unsigned MAX_STEPS = lsq_pkg::MAX_STEPS,
	parameter int unsigned NPINS     = lsq_pkg::NPINS
) (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	input  wire lsq_pkg::apb_req_t apb_req,
	output lsq_pkg::apb_rsp_t      apb_rsp,
	input  wire logic [NPINS-1:0]  dio_in,
	output lsq_pkg::setpt_t        set_out,
	output logic                   trig_out,
	output logic                   busy
);
	localparam int unsigned PRE_W = $clog2(SEC_CYC);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	lsq_pkg::entry_t             list_q [MAX_STEPS];
	lsq_pkg::idx_t               len_q, sel_q, idx_q, idx_d, nxt_idx;
	lsq_pkg::cfg_t               cfg_q, wcfg;
	lsq_pkg::state_t             state_q, state_d;
	lsq_pkg::apb_rsp_t           rsp_q;
	lsq_pkg::setpt_t             set_q;
	lsq_pkg::entry_t             cur, sel_ent;
	logic [lsq_pkg::VAL_W-1:0]   dcv_q, dci_q, trv_q, tri_q;
	logic [lsq_pkg::DLY_W-1:0]   dly_q;
	logic [lsq_pkg::CNT_W-1:0]   cnt_q, pass_q, pass_d, pass_inc;
	logic [NPINS-1:0]            tin_en_q, tin_pos_q, dio_prev_q, pin_edge;
	logic [PRE_W-1:0]            pre_q;
	logic [lsq_pkg::TIME_W-1:0]  sec_q;
	logic [lsq_pkg::TOUT_W-1:0]  tout_q, tout_d;
	logic                        hold_q, hold_d, step_q, step_d, trig_q, busy_q;
	logic                        acc, wr_ok, err_d, locked, bad_combo, list_reg;
	logic                        a_ctrl, a_cfg, a_sel, a_stv, a_sti, a_stt, a_dcv, a_dci;
	logic                        a_trv, a_tri, a_dly, a_cnt, a_stat, a_dio;
	logic                        add_ok, del_ok, clr_ok, init_w, abort_w, key_w, rmt_w;
	logic                        trig_hit, any_list, any_step, last_w, live;
	logic                        run_done, dly_done, adv, done_w, tmr_clr, f_bos, f_eos;
	logic [31:0]                 wd, rd_d;

	function automatic logic [lsq_pkg::VAL_W-1:0] pick(
		input lsq_pkg::mode_t            m,
		input logic [lsq_pkg::VAL_W-1:0] dc,
		input logic [lsq_pkg::VAL_W-1:0] trg,
		input logic [lsq_pkg::VAL_W-1:0] lst,
		input logic                      lv,
		input logic                      stp
	);
		if (m == lsq_pkg::MODE_LIST && lv) begin
			pick = lst;
		end else if (m == lsq_pkg::MODE_STEP && stp) begin
			pick = trg;
		end else begin
			pick = dc;
		end
	endfunction

	// Register bus decode; a write to a list property while initiated is refused.
	assign wd     = apb_req.pwdata;
	assign acc    = apb_req.psel && apb_req.penable && !rsp_q.pready;
	assign a_ctrl = apb_req.paddr == lsq_pkg::OFF_CTRL;
	assign a_cfg  = apb_req.paddr == lsq_pkg::OFF_CFG;
	assign a_sel  = apb_req.paddr == lsq_pkg::OFF_SEL;
	assign a_stv  = apb_req.paddr == lsq_pkg::OFF_STV;
	assign a_sti  = apb_req.paddr == lsq_pkg::OFF_STI;
	assign a_stt  = apb_req.paddr == lsq_pkg::OFF_STT;
	assign a_dcv  = apb_req.paddr == lsq_pkg::OFF_DCV;
	assign a_dci  = apb_req.paddr == lsq_pkg::OFF_DCI;
	assign a_trv  = apb_req.paddr == lsq_pkg::OFF_TRV;
	assign a_tri  = apb_req.paddr == lsq_pkg::OFF_TRI;
	assign a_dly  = apb_req.paddr == lsq_pkg::OFF_DLY;
	assign a_cnt  = apb_req.paddr == lsq_pkg::OFF_CNT;
	assign a_stat = apb_req.paddr == lsq_pkg::OFF_STAT;
	assign a_dio  = apb_req.paddr == lsq_pkg::OFF_DIO;
	assign wcfg   = lsq_pkg::cfg_t'(wd[lsq_pkg::CFG_W-1:0]);
	assign locked = state_q != lsq_pkg::ST_IDLE;
	assign bad_combo = (wcfg.vmode == lsq_pkg::MODE_STEP && wcfg.imode == lsq_pkg::MODE_LIST)
		|| (wcfg.vmode == lsq_pkg::MODE_LIST && wcfg.imode == lsq_pkg::MODE_STEP);
	assign list_reg = a_cfg || a_stv || a_sti || a_stt || a_dly || a_cnt
		|| (a_ctrl && |wd[lsq_pkg::C_CLR:lsq_pkg::C_ADD]);
	assign sel_ent = list_q[sel_q];

	always_comb begin
		rd_d  = 32'h0000_0000;
		err_d = apb_req.pwrite && locked && list_reg;
		if (a_ctrl) begin
			rd_d = 32'h0000_0000;
		end else if (a_cfg) begin
			rd_d = 32'(cfg_q);
			err_d = err_d || (apb_req.pwrite && bad_combo);
		end else if (a_sel) begin
			rd_d = 32'(sel_q);
			err_d = apb_req.pwrite && (len_q == '0 ? wd != 0 : wd >= 32'(len_q));
		end else if (a_stv || a_sti || a_stt) begin
			if (len_q != '0 && a_stv) begin
				rd_d = 32'(sel_ent.v);
			end else if (len_q != '0 && a_sti) begin
				rd_d = 32'(sel_ent.i);
			end else if (len_q != '0) begin
				rd_d = {14'h0000, sel_ent.eos, sel_ent.bos, sel_ent.t};
			end
			err_d = err_d || (apb_req.pwrite && len_q == '0);
		end else if (a_dcv) begin
			rd_d = 32'(dcv_q);
		end else if (a_dci) begin
			rd_d = 32'(dci_q);
		end else if (a_trv) begin
			rd_d = 32'(trv_q);
		end else if (a_tri) begin
			rd_d = 32'(tri_q);
		end else if (a_dly) begin
			rd_d = 32'(dly_q);
			err_d = err_d || (apb_req.pwrite && wd > lsq_pkg::DLY_MAX);
		end else if (a_cnt) begin
			rd_d = 32'(cnt_q);
			err_d = err_d || (apb_req.pwrite
				&& (wd < lsq_pkg::CNT_MIN || wd > lsq_pkg::CNT_MAX));
		end else if (a_stat) begin
			rd_d = 32'(state_q) | (32'(idx_q) << lsq_pkg::S_IDX)
				| (32'(len_q) << lsq_pkg::S_LEN) | (32'(pass_q) << lsq_pkg::S_PASS);
		end else if (a_dio) begin
			rd_d = 32'(tin_en_q) | (32'(tin_pos_q) << lsq_pkg::D_POL);
		end else begin
			err_d = 1'b1;
		end
	end

	assign wr_ok   = acc && apb_req.pwrite && !err_d;
	assign init_w  = wr_ok && a_ctrl && wd[lsq_pkg::C_INIT];
	assign abort_w = wr_ok && a_ctrl && wd[lsq_pkg::C_ABORT];
	assign key_w   = wr_ok && a_ctrl && wd[lsq_pkg::C_KEY];
	assign rmt_w   = wr_ok && a_ctrl && wd[lsq_pkg::C_RMT];
	assign clr_ok  = wr_ok && a_ctrl && wd[lsq_pkg::C_CLR];
	assign del_ok  = wr_ok && a_ctrl && wd[lsq_pkg::C_DEL] && !clr_ok && len_q != '0;
	assign add_ok  = wr_ok && a_ctrl && wd[lsq_pkg::C_ADD] && !clr_ok && !wd[lsq_pkg::C_DEL]
		&& len_q < lsq_pkg::idx_t'(MAX_STEPS);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rsp_q     <= '0;
			cfg_q     <= lsq_pkg::CFG_RST;
			dly_q     <= lsq_pkg::DLY_RST;
			cnt_q     <= lsq_pkg::CNT_RST;
			{dcv_q, dci_q, trv_q, tri_q} <= '0;
			{tin_en_q, tin_pos_q} <= '0;
		end else if (ce) begin
			rsp_q.pready  <= acc;
			rsp_q.pslverr <= acc && err_d;
			rsp_q.prdata  <= acc && !apb_req.pwrite ? rd_d : 32'h0000_0000;
			if (wr_ok && a_cfg) cfg_q <= wcfg;
			if (wr_ok && a_dly) dly_q <= wd[lsq_pkg::DLY_W-1:0];
			if (wr_ok && a_cnt) cnt_q <= wd[lsq_pkg::CNT_W-1:0];
			if (wr_ok && a_dcv) dcv_q <= wd[lsq_pkg::VAL_W-1:0];
			if (wr_ok && a_dci) dci_q <= wd[lsq_pkg::VAL_W-1:0];
			if (wr_ok && a_trv) trv_q <= wd[lsq_pkg::VAL_W-1:0];
			if (wr_ok && a_tri) tri_q <= wd[lsq_pkg::VAL_W-1:0];
			if (wr_ok && a_dio) begin
				tin_en_q  <= wd[NPINS-1:0];
				tin_pos_q <= wd[lsq_pkg::D_POL +: NPINS];
			end
		end
	end

	// List storage has no reset: the length register alone says what is valid.
	always_ff @(posedge clk_sys) begin
		if (ce && !sys_rst) begin
			for (int k = 1; k < MAX_STEPS; k++) begin
				if (add_ok && len_q != '0 && lsq_pkg::idx_t'(k) > sel_q) begin
					list_q[k] <= list_q[k-1];
				end
			end
			for (int k = 0; k < MAX_STEPS - 1; k++) begin
				if (del_ok && lsq_pkg::idx_t'(k) >= sel_q) begin
					list_q[k] <= list_q[k+1];
				end
			end
			if (add_ok && len_q == '0) list_q[0] <= '0;
			if (wr_ok && a_stv) list_q[sel_q].v <= wd[lsq_pkg::VAL_W-1:0];
			if (wr_ok && a_sti) list_q[sel_q].i <= wd[lsq_pkg::VAL_W-1:0];
			if (wr_ok && a_stt) begin
				list_q[sel_q].t   <= wd[lsq_pkg::TIME_W-1:0];
				list_q[sel_q].bos <= wd[lsq_pkg::T_BOS];
				list_q[sel_q].eos <= wd[lsq_pkg::T_EOS];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			len_q <= '0;
			sel_q <= '0;
		end else if (ce) begin
			if (clr_ok) begin
				len_q <= '0;
				sel_q <= '0;
			end else if (add_ok) begin
				len_q <= len_q + 1'b1;
				sel_q <= len_q == '0 ? '0 : sel_q + 1'b1;
			end else if (del_ok) begin
				len_q <= len_q - 1'b1;
				if (sel_q == len_q - 1'b1 && sel_q != '0) sel_q <= sel_q - 1'b1;
			end else if (wr_ok && a_sel) begin
				sel_q <= wd[lsq_pkg::IDX_W-1:0];
			end
		end
	end

	// Pins are sampled on clk_sys, so an input pulse must span at least one rising edge.
	assign pin_edge = tin_en_q & ((tin_pos_q & dio_in & ~dio_prev_q)
		| (~tin_pos_q & ~dio_in & dio_prev_q));
	assign trig_hit = (cfg_q.src == lsq_pkg::SRC_KEY && key_w)
		|| (cfg_q.src == lsq_pkg::SRC_IO && |pin_edge)
		|| (cfg_q.src == lsq_pkg::SRC_RMT && rmt_w);
	assign any_list = cfg_q.vmode == lsq_pkg::MODE_LIST || cfg_q.imode == lsq_pkg::MODE_LIST;
	assign any_step = cfg_q.vmode == lsq_pkg::MODE_STEP || cfg_q.imode == lsq_pkg::MODE_STEP;
	assign cur      = list_q[idx_q];
	assign nxt_idx  = idx_q + 1'b1;
	assign last_w   = nxt_idx == len_q;
	assign pass_inc = pass_q + 1'b1;
	assign run_done = sec_q >= cur.t;
	assign dly_done = sec_q >= lsq_pkg::TIME_W'(dly_q);
	assign adv = (state_q == lsq_pkg::ST_RUN && !cfg_q.pace_trg && run_done)
		|| (state_q == lsq_pkg::ST_ADELAY && dly_done);

	always_comb begin
		state_d = state_q;
		idx_d   = idx_q;
		pass_d  = pass_q;
		hold_d  = hold_q;
		step_d  = step_q;
		tmr_clr = 1'b0;
		f_bos   = 1'b0;
		f_eos   = 1'b0;
		done_w  = 1'b0;
		case (state_q)
			lsq_pkg::ST_IDLE: begin
				if (init_w) begin
					state_d = lsq_pkg::ST_ARMED;
					hold_d  = 1'b0;
					step_d  = 1'b0;
				end
			end
			lsq_pkg::ST_ARMED: begin
				if (trig_hit) begin
					state_d = lsq_pkg::ST_DELAY;
					tmr_clr = 1'b1;
				end
			end
			lsq_pkg::ST_DELAY: begin
				if (dly_done && any_list && len_q != '0) begin
					state_d = lsq_pkg::ST_RUN;
					idx_d   = '0;
					pass_d  = '0;
					tmr_clr = 1'b1;
					f_bos   = list_q[0].bos;
				end else if (dly_done) begin
					state_d = lsq_pkg::ST_IDLE;
					step_d  = any_step;
				end
			end
			lsq_pkg::ST_RUN: begin
				// An expired step under trigger pacing just waits here.
				if (cfg_q.pace_trg && trig_hit) begin
					state_d = lsq_pkg::ST_ADELAY;
					tmr_clr = 1'b1;
				end
			end
			default: begin
			end
		endcase
		if (adv) begin
			f_eos   = cur.eos;
			tmr_clr = 1'b1;
			if (!last_w) begin
				state_d = lsq_pkg::ST_RUN;
				idx_d   = nxt_idx;
				f_bos   = list_q[nxt_idx].bos;
			end else if (cfg_q.cont || pass_inc < cnt_q) begin
				state_d = lsq_pkg::ST_RUN;
				idx_d   = '0;
				pass_d  = cfg_q.cont ? pass_q : pass_inc;
				f_bos   = list_q[0].bos;
			end else begin
				state_d = lsq_pkg::ST_IDLE;
				pass_d  = pass_inc;
				done_w  = 1'b1;
				hold_d  = cfg_q.after_list;
			end
		end
		if (abort_w) begin
			state_d = lsq_pkg::ST_IDLE;
			hold_d  = 1'b0;
			f_bos   = 1'b0;
			f_eos   = 1'b0;
		end
	end

	assign live   = state_q == lsq_pkg::ST_RUN || state_q == lsq_pkg::ST_ADELAY || hold_q;
	// A begin and an end event in one cycle merge into a single pulse.
	assign tout_d = (f_bos || f_eos) ? lsq_pkg::TOUT_W'(lsq_pkg::TOUT_CYC)
		: (tout_q != '0 ? tout_q - 1'b1 : tout_q);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q    <= lsq_pkg::ST_IDLE;
			{idx_q, pass_q, hold_q, step_q, tout_q, busy_q} <= '0;
			{pre_q, sec_q, dio_prev_q, set_q} <= '0;
			trig_q     <= lsq_pkg::CFG_RST.tout_pos ? 1'b0 : 1'b1;
		end else if (ce) begin
			state_q    <= state_d;
			idx_q      <= idx_d;
			pass_q     <= pass_d;
			hold_q     <= hold_d;
			step_q     <= step_d;
			tout_q     <= tout_d;
			busy_q     <= state_d != lsq_pkg::ST_IDLE;
			dio_prev_q <= dio_in;
			trig_q     <= (tout_d != '0) == cfg_q.tout_pos;
			set_q.v    <= pick(cfg_q.vmode, dcv_q, trv_q, cur.v, live, step_q);
			set_q.i    <= pick(cfg_q.imode, dci_q, tri_q, cur.i, live, step_q);
			if (tmr_clr || pre_q == PRE_W'(SEC_CYC - 1)) begin
				pre_q <= '0;
			end else begin
				pre_q <= pre_q + 1'b1;
			end
			if (tmr_clr) begin
				sec_q <= '0;
			end else if (pre_q == PRE_W'(SEC_CYC - 1) && sec_q != '1) begin
				sec_q <= sec_q + 1'b1;
			end
		end
	end

	assign apb_rsp  = rsp_q;
	assign set_out  = set_q;
	assign trig_out = trig_q;
	assign busy     = busy_q;

	sequence s_bos;
		ce && f_bos;
	endsequence
	sequence s_eos;
		ce && f_eos && !f_bos;
	endsequence
	property p_len_cap;
		len_q <= lsq_pkg::idx_t'(MAX_STEPS);
	endproperty
	a_len_cap: assert property (p_len_cap) else $error("list too long");
	property p_add;
		ce && add_ok |=> len_q == $past(len_q) + 1'b1;
	endproperty
	a_add: assert property (p_add) else $error("add did not grow list");
	property p_copy;
		ce && add_ok && len_q != '0 |=> sel_ent == $past(sel_ent);
	endproperty
	a_copy: assert property (p_copy) else $error("new entry not a copy");
	property p_clr;
		ce && clr_ok |=> len_q == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("clear left entries");
	property p_bos;
		s_bos |=> tout_q == lsq_pkg::TOUT_W'(lsq_pkg::TOUT_CYC) ##1 tout_q != '0;
	endproperty
	a_bos: assert property (p_bos) else $error("no begin pulse");
	property p_eos;
		s_eos |=> tout_q == lsq_pkg::TOUT_W'(lsq_pkg::TOUT_CYC);
	endproperty
	a_eos: assert property (p_eos) else $error("no end pulse");
	property p_dc;
		ce && done_w && !cfg_q.after_list |=> !hold_q && state_q == lsq_pkg::ST_IDLE;
	endproperty
	a_dc: assert property (p_dc) else $error("no revert after list");
	property p_hold;
		ce && done_w && cfg_q.after_list && !abort_w |=> hold_q && idx_q == $past(idx_q);
	endproperty
	a_hold: assert property (p_hold) else $error("last step not held");
	property p_dwell;
		ce && adv && !last_w && !abort_w |=> idx_q == $past(nxt_idx)
			&& state_q == lsq_pkg::ST_RUN;
	endproperty
	a_dwell: assert property (p_dwell) else $error("step did not advance");
	property p_fix;
		ce && cfg_q.vmode == lsq_pkg::MODE_FIX |=> set_q.v == $past(dcv_q);
	endproperty
	a_fix: assert property (p_fix) else $error("fixed voltage moved");
	property p_combo;
		ce && acc && apb_req.pwrite && a_cfg && bad_combo |=> rsp_q.pslverr
			&& cfg_q == $past(cfg_q);
	endproperty
	a_combo: assert property (p_combo) else $error("bad mode pair taken");
	property p_lock;
		ce && acc && apb_req.pwrite && locked && list_reg |=> rsp_q.pslverr
			&& len_q == $past(len_q);
	endproperty
	a_lock: assert property (p_lock) else $error("locked list changed");
	property p_done;
		ce && done_w |-> !cfg_q.cont ##1 pass_q == $past(cnt_q);
	endproperty
	a_done: assert property (p_done) else $error("completed early");
endmodule
